//--- src/drpc_map.vh
`ifndef DRPC_MAP_VH
`define DRPC_MAP_VH

// Register byte offsets
`define DRPC_OFS_REF_ONE      8'h00
`define DRPC_OFS_REF_TWO      8'h04
`define DRPC_OFS_PWR          8'h08
`define DRPC_OFS_PD_TIMEOUT   8'h0c
`define DRPC_OFS_STATUS       8'h10

// refresh_control_one fields
`define DRPC_RFC_MIN_MSB      14
`define DRPC_RFC_MIN_LSB      7
`define DRPC_UPD_TOGGLE_BIT   6
`define DRPC_SELF_REF_BIT     5
`define DRPC_SPEC_TO_MSB      4
`define DRPC_SPEC_TO_LSB      0

// refresh_control_two fields
`define DRPC_INTERVAL_MSB     14
`define DRPC_INTERVAL_LSB     3
`define DRPC_BURST_MSB        2
`define DRPC_BURST_LSB        0

// power_down_control fields
`define DRPC_PD_EN_BIT        1
`define DRPC_DPD_EN_BIT       0

// power_down_idle_timeout field
`define DRPC_PD_TO_MSB        7
`define DRPC_PD_TO_LSB        0

// Reset values
`define DRPC_RST_RFC_MIN      8'h23
`define DRPC_RST_UPD_TOGGLE   1'h0
`define DRPC_RST_SELF_REF     1'h0
`define DRPC_RST_SPEC_TO      5'h08
`define DRPC_RST_INTERVAL     12'h052
`define DRPC_RST_BURST        3'h0
`define DRPC_RST_PD_EN        1'h1
`define DRPC_RST_DPD_EN       1'h0
`define DRPC_RST_PD_TO        8'h10

// Timer unit
`define DRPC_X32_DIV          6'h20

// DRAM command codes; each exit code is its entry code plus one
`define DRPC_CMD_NOP          4'h0
`define DRPC_CMD_PREA         4'h1
`define DRPC_CMD_REF          4'h2
`define DRPC_CMD_SRE          4'h3
`define DRPC_CMD_SRX          4'h4
`define DRPC_CMD_PDE          4'h5
`define DRPC_CMD_PDX          4'h6
`define DRPC_CMD_DPDE         4'h7
`define DRPC_CMD_DPDX         4'h8

`endif

//--- src/drpc_x32_timer.v
`timescale 1ns/1ps
`include "drpc_map.vh"

// Counts elapsed units of 32 clocks while run_i is high; saturates.
module drpc_x32_timer #(
  parameter W = 12
) (
  input  wire         core_clk_i,
  input  wire         srst_i,
  input  wire         run_i,
  input  wire         clr_i,
  output wire [W-1:0] cnt_o
);
  reg [5:0]   pre_r;
  reg [W-1:0] cnt_r;
  wire        tick;

  assign tick  = (pre_r == (`DRPC_X32_DIV - 6'h01));
  assign cnt_o = cnt_r;

  always @(posedge core_clk_i) begin
    if (srst_i || clr_i || !run_i) begin
      pre_r <= 6'h00;
      if (srst_i || clr_i) begin
        cnt_r <= {W{1'b0}};
      end
    end else begin
      pre_r <= tick ? 6'h00 : pre_r + 6'h01;
      if (tick && (cnt_r != {W{1'b1}})) begin
        cnt_r <= cnt_r + {{(W-1){1'b0}}, 1'b1};
      end
    end
  end
endmodule // drpc_x32_timer

//--- src/drpc_regs.v
`timescale 1ns/1ps
`include "drpc_map.vh"

module drpc_regs (
  input  wire        core_clk_i,
  input  wire        srst_i,
  input  wire        wr_i,
  input  wire        rd_i,
  input  wire [7:0]  addr_i,
  input  wire [31:0] wdata_i,
  input  wire [31:0] status_i,
  output reg  [31:0] rdata_o,
  output reg  [7:0]  rfc_min_o,
  output reg         upd_toggle_o,
  output reg         self_ref_en_o,
  output reg  [4:0]  spec_to_o,
  output reg  [11:0] interval_o,
  output reg  [2:0]  burst_o,
  output reg         pd_en_o,
  output reg         dpd_en_o,
  output reg  [7:0]  pd_to_o
);
  reg [31:0] rd_nxt;

  always @* begin
    rd_nxt = 32'h0000_0000;
    case (addr_i)
      `DRPC_OFS_REF_ONE: begin
        rd_nxt[`DRPC_RFC_MIN_MSB:`DRPC_RFC_MIN_LSB] = rfc_min_o;
        rd_nxt[`DRPC_UPD_TOGGLE_BIT] = upd_toggle_o;
        rd_nxt[`DRPC_SELF_REF_BIT] = self_ref_en_o;
        rd_nxt[`DRPC_SPEC_TO_MSB:`DRPC_SPEC_TO_LSB] = spec_to_o;
      end
      `DRPC_OFS_REF_TWO: begin
        rd_nxt[`DRPC_INTERVAL_MSB:`DRPC_INTERVAL_LSB] = interval_o;
        rd_nxt[`DRPC_BURST_MSB:`DRPC_BURST_LSB] = burst_o;
      end
      `DRPC_OFS_PWR: begin
        rd_nxt[`DRPC_PD_EN_BIT] = pd_en_o;
        rd_nxt[`DRPC_DPD_EN_BIT] = dpd_en_o;
      end
      `DRPC_OFS_PD_TIMEOUT: begin
        rd_nxt[`DRPC_PD_TO_MSB:`DRPC_PD_TO_LSB] = pd_to_o;
      end
      `DRPC_OFS_STATUS: begin
        rd_nxt = status_i;
      end
      default: begin
        rd_nxt = 32'h0000_0000;
      end
    endcase
  end

  // Reserved bits are not stored and read as zero
  always @(posedge core_clk_i) begin
    if (srst_i) begin
      rdata_o       <= 32'h0000_0000;
      rfc_min_o     <= `DRPC_RST_RFC_MIN;
      upd_toggle_o  <= `DRPC_RST_UPD_TOGGLE;
      self_ref_en_o <= `DRPC_RST_SELF_REF;
      spec_to_o     <= `DRPC_RST_SPEC_TO;
      interval_o    <= `DRPC_RST_INTERVAL;
      burst_o       <= `DRPC_RST_BURST;
      pd_en_o       <= `DRPC_RST_PD_EN;
      dpd_en_o      <= `DRPC_RST_DPD_EN;
      pd_to_o       <= `DRPC_RST_PD_TO;
    end else begin
      if (rd_i) begin
        rdata_o <= rd_nxt;
      end
      if (wr_i) begin
        case (addr_i)
          `DRPC_OFS_REF_ONE: begin
            rfc_min_o     <= wdata_i[`DRPC_RFC_MIN_MSB:`DRPC_RFC_MIN_LSB];
            upd_toggle_o  <= wdata_i[`DRPC_UPD_TOGGLE_BIT];
            self_ref_en_o <= wdata_i[`DRPC_SELF_REF_BIT];
            spec_to_o     <= wdata_i[`DRPC_SPEC_TO_MSB:`DRPC_SPEC_TO_LSB];
          end
          `DRPC_OFS_REF_TWO: begin
            interval_o <= wdata_i[`DRPC_INTERVAL_MSB:`DRPC_INTERVAL_LSB];
            burst_o    <= wdata_i[`DRPC_BURST_MSB:`DRPC_BURST_LSB];
          end
          `DRPC_OFS_PWR: begin
            pd_en_o  <= wdata_i[`DRPC_PD_EN_BIT];
            dpd_en_o <= wdata_i[`DRPC_DPD_EN_BIT];
          end
          `DRPC_OFS_PD_TIMEOUT: begin
            pd_to_o <= wdata_i[`DRPC_PD_TO_MSB:`DRPC_PD_TO_LSB];
          end
          default: begin
            pd_to_o <= pd_to_o;
          end
        endcase
      end
    end
  end
endmodule // drpc_regs

//--- src/drpc_ctrl.v
`timescale 1ns/1ps
`include "drpc_map.vh"

module drpc_ctrl #(
  parameter MOBILE_EN = 1
) (
  input  wire        core_clk_i,
  input  wire        srst_i,
  input  wire        reg_wr_i,
  input  wire        reg_rd_i,
  input  wire [7:0]  reg_addr_i,
  input  wire [31:0] reg_wdata_i,
  output wire [31:0] reg_rdata_o,
  input  wire        soft_rst_n_i,
  input  wire        store_empty_i,
  output wire        cmd_valid_o,
  output wire [3:0]  cmd_code_o,
  input  wire        cmd_ready_i,
  output wire        block_traffic_o,
  output wire        act_allowed_o,
  output wire        low_power_o
);
  localparam [3:0] ST_IDLE = 4'h1;
  localparam [3:0] ST_PRE  = 4'h2;
  localparam [3:0] ST_REF  = 4'h4;
  localparam [3:0] ST_LP   = 4'h8;

  wire [7:0]  cfg_rfc_min;
  wire        cfg_upd_toggle;
  wire        cfg_self_ref;
  wire [4:0]  cfg_spec_to;
  wire [11:0] cfg_interval;
  wire [2:0]  cfg_burst;
  wire        cfg_pd_en;
  wire        cfg_dpd_raw;
  wire [7:0]  cfg_pd_to;
  wire [31:0] status;
  wire [11:0] int_cnt;
  wire [7:0]  idle_cnt;

  reg [7:0]  rfc_min_r;
  reg [11:0] interval_r;
  reg [2:0]  burst_r;
  reg        toggle_seen_r;
  reg [3:0]  state_r;
  reg [3:0]  goal_r;
  reg        lp_in_r;
  reg        early_r;
  reg        cmd_valid_r;
  reg [3:0]  cmd_code_r;
  reg [7:0]  rfc_cnt_r;
  reg [3:0]  pending_r;
  reg [3:0]  pending_nxt;

  wire cfg_dpd_en = cfg_dpd_raw && (MOBILE_EN != 0);
  wire ack        = cmd_valid_r && cmd_ready_i;
  wire ref_done   = ack && (cmd_code_r == `DRPC_CMD_REF);
  wire int_due    = (interval_r != 12'h000) && (int_cnt >= interval_r);
  wire int_timeout = int_due && soft_rst_n_i;
  wire refresh_freeze = (state_r == ST_LP) && lp_in_r &&
                        (goal_r != `DRPC_CMD_PDE);
  wire idle_run   = soft_rst_n_i && store_empty_i && (state_r == ST_IDLE) &&
                    !cmd_valid_r;
  wire force_ref  = (pending_r > {1'b0, burst_r});
  wire spec_ok    = (idle_cnt >= {3'h0, cfg_spec_to}) &&
                    ((pending_r != 4'h0) ||
                     (int_cnt >= {1'b0, interval_r[11:1]}));
  wire pd_ok      = cfg_pd_en && (idle_cnt >= cfg_pd_to);
  wire lp_exit    = (goal_r == `DRPC_CMD_SRE) ?
                      (!cfg_self_ref || !store_empty_i) :
                    (goal_r == `DRPC_CMD_PDE) ?
                      (!cfg_pd_en || !store_empty_i || force_ref) :
                      !cfg_dpd_en;

  drpc_regs u_regs (
    .core_clk_i    (core_clk_i),
    .srst_i        (srst_i),
    .wr_i          (reg_wr_i),
    .rd_i          (reg_rd_i),
    .addr_i        (reg_addr_i),
    .wdata_i       (reg_wdata_i),
    .status_i      (status),
    .rdata_o       (reg_rdata_o),
    .rfc_min_o     (cfg_rfc_min),
    .upd_toggle_o  (cfg_upd_toggle),
    .self_ref_en_o (cfg_self_ref),
    .spec_to_o     (cfg_spec_to),
    .interval_o    (cfg_interval),
    .burst_o       (cfg_burst),
    .pd_en_o       (cfg_pd_en),
    .dpd_en_o      (cfg_dpd_raw),
    .pd_to_o       (cfg_pd_to)
  );

  // Early refresh pays off the interval in progress
  drpc_x32_timer #(
    .W (12)
  ) u_int_timer (
    .core_clk_i (core_clk_i),
    .srst_i     (srst_i),
    .run_i      (soft_rst_n_i && !refresh_freeze),
    .clr_i      (int_due || !soft_rst_n_i || (ref_done && early_r)),
    .cnt_o      (int_cnt)
  );

  drpc_x32_timer #(
    .W (8)
  ) u_idle_timer (
    .core_clk_i (core_clk_i),
    .srst_i     (srst_i),
    .run_i      (idle_run),
    .clr_i      (!idle_run),
    .cnt_o      (idle_cnt)
  );

  assign status = {22'h000000, act_allowed_o, block_traffic_o,
                   pending_r, state_r};
  assign cmd_valid_o     = cmd_valid_r;
  assign cmd_code_o      = cmd_code_r;
  assign block_traffic_o = (state_r != ST_IDLE);
  assign act_allowed_o   = (rfc_cnt_r == 8'h00);
  assign low_power_o     = (state_r == ST_LP) && lp_in_r;

  // Active refresh settings
  always @(posedge core_clk_i) begin
    if (srst_i) begin
      rfc_min_r     <= `DRPC_RST_RFC_MIN;
      interval_r    <= `DRPC_RST_INTERVAL;
      burst_r       <= `DRPC_RST_BURST;
      toggle_seen_r <= `DRPC_RST_UPD_TOGGLE;
    end else if (!soft_rst_n_i ||
                 (cfg_upd_toggle != toggle_seen_r)) begin
      rfc_min_r     <= cfg_rfc_min;
      interval_r    <= cfg_interval;
      burst_r       <= cfg_burst;
      toggle_seen_r <= cfg_upd_toggle;
    end
  end

  always @* begin
    pending_nxt = pending_r;
    if (int_timeout && !(ref_done && (pending_r != 4'h0))) begin
      if (pending_r != 4'hf) begin
        pending_nxt = pending_r + 4'h1;
      end
    end else if (!int_timeout && ref_done && (pending_r != 4'h0)) begin
      pending_nxt = pending_r - 4'h1;
    end
  end

  always @(posedge core_clk_i) begin
    if (srst_i || !soft_rst_n_i) begin
      state_r     <= ST_IDLE;
      goal_r      <= `DRPC_CMD_NOP;
      lp_in_r     <= 1'b0;
      early_r     <= 1'b0;
      cmd_valid_r <= 1'b0;
      cmd_code_r  <= `DRPC_CMD_NOP;
      rfc_cnt_r   <= 8'h00;
      pending_r   <= 4'h0;
    end else begin
      pending_r <= pending_nxt;
      if (ref_done) begin
        rfc_cnt_r <= rfc_min_r;
      end else if (rfc_cnt_r != 8'h00) begin
        rfc_cnt_r <= rfc_cnt_r - 8'h01;
      end
      if (cmd_valid_r) begin
        if (cmd_ready_i) begin
          cmd_valid_r <= 1'b0;
          case (cmd_code_r)
            `DRPC_CMD_PREA: begin
              state_r <= (goal_r == `DRPC_CMD_REF) ? ST_REF : ST_LP;
              lp_in_r <= 1'b0;
            end
            `DRPC_CMD_REF: begin
              early_r <= 1'b0;
            end
            `DRPC_CMD_SRE, `DRPC_CMD_PDE, `DRPC_CMD_DPDE: begin
              lp_in_r <= 1'b1;
            end
            `DRPC_CMD_SRX, `DRPC_CMD_PDX, `DRPC_CMD_DPDX: begin
              lp_in_r <= 1'b0;
              state_r <= ST_IDLE;
            end
            default: begin
              state_r <= ST_IDLE;
            end
          endcase
        end
      end else begin
        case (state_r)
          ST_IDLE: begin
            if (force_ref || (idle_run && spec_ok)) begin
              early_r     <= (pending_r == 4'h0);
              goal_r      <= `DRPC_CMD_REF;
              cmd_code_r  <= `DRPC_CMD_PREA;
              cmd_valid_r <= 1'b1;
              state_r     <= ST_PRE;
            end else if (store_empty_i &&
                         (cfg_dpd_en || cfg_self_ref || pd_ok)) begin
              if (cfg_dpd_en) begin
                goal_r <= `DRPC_CMD_DPDE;
              end else if (cfg_self_ref) begin
                goal_r <= `DRPC_CMD_SRE;
              end else begin
                goal_r <= `DRPC_CMD_PDE;
              end
              cmd_code_r  <= `DRPC_CMD_PREA;
              cmd_valid_r <= 1'b1;
              state_r     <= ST_PRE;
            end
          end
          ST_PRE: begin
            state_r <= ST_PRE;
          end
          ST_REF: begin
            // Back to back until the debt is paid; pages stay closed
            if ((pending_r == 4'h0) && !early_r) begin
              state_r <= ST_IDLE;
            end else if (rfc_cnt_r == 8'h00) begin
              cmd_code_r  <= `DRPC_CMD_REF;
              cmd_valid_r <= 1'b1;
            end
          end
          ST_LP: begin
            if (!lp_in_r) begin
              cmd_code_r  <= goal_r;
              cmd_valid_r <= 1'b1;
            end else if (lp_exit) begin
              cmd_code_r  <= goal_r + 4'h1;
              cmd_valid_r <= 1'b1;
            end
          end
          default: begin
            state_r <= ST_IDLE;
          end
        endcase
      end
    end
  end
endmodule // drpc_ctrl

//--- dv/drpc_ctrl_checker.sv
`timescale 1ns/1ps
`include "drpc_map.vh"
module drpc_ctrl_checker (
  input wire        core_clk_i,
  input wire        srst_i,
  input wire        reg_wr_i,
  input wire [7:0]  reg_addr_i,
  input wire [31:0] reg_wdata_i,
  input wire        soft_rst_n_i,
  input wire        cmd_valid_o,
  input wire [3:0]  cmd_code_o,
  input wire        cmd_ready_i,
  input wire        block_traffic_o,
  input wire        act_allowed_o,
  input wire        low_power_o
);
  reg  [3:0] last_r;
  reg  [7:0] rfc_wr_r;
  reg  [7:0] rfc_act_r;
  reg        tog_r;
  reg        tog_q_r;
  reg  [8:0] low_r;
  wire       acc = cmd_valid_o & cmd_ready_i;
  wire       is_ref = cmd_code_o == `DRPC_CMD_REF;
  wire       is_ent = cmd_code_o == `DRPC_CMD_SRE ||
                      cmd_code_o == `DRPC_CMD_PDE ||
                      cmd_code_o == `DRPC_CMD_DPDE;
  wire       is_ext = cmd_code_o == `DRPC_CMD_SRX ||
                      cmd_code_o == `DRPC_CMD_PDX ||
                      cmd_code_o == `DRPC_CMD_DPDX;

  // Mirror of the active recovery time, adopted like the design's copy
  always @(posedge core_clk_i) begin
    if (srst_i) begin
      last_r    <= `DRPC_CMD_NOP;
      rfc_wr_r  <= `DRPC_RST_RFC_MIN;
      rfc_act_r <= `DRPC_RST_RFC_MIN;
      tog_r     <= 1'b0;
      tog_q_r   <= 1'b0;
      low_r     <= 9'h000;
    end else begin
      if (acc)
        last_r <= cmd_code_o;
      if (reg_wr_i && reg_addr_i == `DRPC_OFS_REF_ONE) begin
        rfc_wr_r <= reg_wdata_i[14:7];
        tog_r    <= reg_wdata_i[6];
      end
      tog_q_r <= tog_r;
      if (!soft_rst_n_i || tog_q_r != tog_r)
        rfc_act_r <= rfc_wr_r;
      if (acc && is_ref)
        low_r <= 9'h000;
      else if (!act_allowed_o && low_r != 9'h1ff)
        low_r <= low_r + 9'h001;
    end
  end

  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (srst_i);

  sequence s_ref_acc;  acc && is_ref; endsequence
  sequence s_ent_acc;  acc && is_ent; endsequence
  sequence s_ext_acc;  acc && is_ext; endsequence
  sequence s_new_cmd;  $rose(cmd_valid_o); endsequence

  a_cmd_hold: assert property (cmd_valid_o && !cmd_ready_i |=>
    cmd_valid_o && $stable(cmd_code_o))
    else $error("command changed before accept");
  a_cmd_gap: assert property (acc |=> !cmd_valid_o)
    else $error("command kept after accept");
  a_ref_order: assert property (s_new_cmd ##0 is_ref |->
    last_r == `DRPC_CMD_PREA || last_r == `DRPC_CMD_REF)
    else $error("refresh without precharge");
  a_entry_order: assert property (s_new_cmd ##0 is_ent |->
    last_r == `DRPC_CMD_PREA)
    else $error("low-power entry without precharge");
  a_exit_pair: assert property (s_new_cmd ##0 is_ext |->
    last_r == cmd_code_o - 4'h1)
    else $error("exit does not match entry");
  a_ref_blocks: assert property (cmd_valid_o && is_ref |->
    block_traffic_o && act_allowed_o)
    else $error("refresh while not blocked");
  a_recov_start: assert property (s_ref_acc |=> !act_allowed_o)
    else $error("activate allowed right after refresh");
  a_recov_len: assert property ($rose(act_allowed_o) |->
    low_r >= {1'b0, rfc_act_r})
    else $error("recovery time too short");
  a_lp_on: assert property (s_ent_acc |=> low_power_o [*2])
    else $error("low power not shown after entry");
  a_lp_off: assert property (s_ext_acc |=> !low_power_o)
    else $error("low power shown after exit");
  a_soft_rst: assert property (!soft_rst_n_i |=>
    !cmd_valid_o && !block_traffic_o)
    else $error("activity in soft reset");
  a_rst_state: assert property ($fell(srst_i) |->
    !cmd_valid_o && act_allowed_o && !low_power_o)
    else $error("bad state after reset");
endmodule // drpc_ctrl_checker

bind drpc_ctrl drpc_ctrl_checker chk_u (
  .core_clk_i(core_clk_i), .srst_i(srst_i), .reg_wr_i(reg_wr_i),
  .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
  .soft_rst_n_i(soft_rst_n_i), .cmd_valid_o(cmd_valid_o),
  .cmd_code_o(cmd_code_o), .cmd_ready_i(cmd_ready_i),
  .block_traffic_o(block_traffic_o), .act_allowed_o(act_allowed_o),
  .low_power_o(low_power_o));

//--- dv/drpc_dram_model.sv
`timescale 1ns/1ps
`include "drpc_map.vh"
module drpc_dram_model (
  input  wire       core_clk_i,
  input  wire       srst_i,
  input  wire       cmd_valid_i,
  input  wire [3:0] cmd_code_i,
  input  wire [3:0] lag_i,
  output wire       cmd_ready_o,
  output reg        bad_o
);
  reg [3:0] wait_r;
  reg [3:0] mode_r;
  // Slow answers stretch each command by lag_i cycles
  assign cmd_ready_o = cmd_valid_i && (wait_r >= lag_i);
  always @(posedge core_clk_i) begin
    if (srst_i) begin
      wait_r <= 4'h0;
      mode_r <= `DRPC_CMD_NOP;
      bad_o  <= 1'b0;
    end else if (cmd_valid_i && !cmd_ready_o) begin
      wait_r <= wait_r + 4'h1;
    end else if (cmd_ready_o) begin
      wait_r <= 4'h0;
      case (cmd_code_i)
        `DRPC_CMD_SRE, `DRPC_CMD_PDE, `DRPC_CMD_DPDE: begin
          bad_o  <= bad_o | (mode_r != `DRPC_CMD_NOP);
          mode_r <= cmd_code_i;
        end
        `DRPC_CMD_SRX, `DRPC_CMD_PDX, `DRPC_CMD_DPDX: begin
          bad_o  <= bad_o | (mode_r != cmd_code_i - 4'h1);
          mode_r <= `DRPC_CMD_NOP;
        end
        default:
          bad_o <= bad_o | (mode_r != `DRPC_CMD_NOP);
      endcase
    end
  end
endmodule // drpc_dram_model

//--- dv/drpc_ctrl_test.sv
`timescale 1ns/1ps
`include "drpc_map.vh"
module drpc_ctrl_test;
  logic        clk, srst, wr_en, rd_en, soft_n, empty;
  logic [7:0]  addr;
  logic [31:0] wdata, rdata, v;
  logic        valid, ready, blk, act, lp, bad;
  logic [3:0]  code, lag;
  logic [3:0]  q[$];
  int          err_count, samples_checked;

  drpc_ctrl #(.MOBILE_EN(1)) dut_u (
    .core_clk_i(clk), .srst_i(srst), .reg_wr_i(wr_en), .reg_rd_i(rd_en),
    .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_rdata_o(rdata),
    .soft_rst_n_i(soft_n), .store_empty_i(empty), .cmd_valid_o(valid),
    .cmd_code_o(code), .cmd_ready_i(ready), .block_traffic_o(blk),
    .act_allowed_o(act), .low_power_o(lp));
  drpc_dram_model mdl_u (
    .core_clk_i(clk), .srst_i(srst), .cmd_valid_i(valid), .cmd_code_i(code),
    .lag_i(lag), .cmd_ready_o(ready), .bad_o(bad));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  always @(posedge clk)
    if (valid === 1'b1 && ready === 1'b1) q.push_back(code);

  task check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(negedge clk); addr = a; wdata = d; wr_en = 1'b1;
    @(negedge clk); wr_en = 1'b0;
  endtask
  task rd(input logic [7:0] a, output logic [31:0] d);
    @(negedge clk); addr = a; rd_en = 1'b1;
    @(negedge clk); rd_en = 1'b0; d = rdata;
  endtask
  task rdc(input logic [7:0] a, input logic [31:0] e, input string nm);
    logic [31:0] d;
    rd(a, d);
    check(nm, d, e);
  endtask
  // Bounded wait so a missing command cannot hang the run
  task exp_cmd(input logic [3:0] c);
    int n;
    n = 0;
    while (q.size() == 0 && n < 2000) begin
      @(negedge clk);
      n++;
    end
    check("cmd", (q.size() != 0) ? {28'h0, q.pop_front()} : 32'hffff,
          {28'h0, c});
  endtask
  task summarize;
    $display("mismatches %0d comparisons %0d", err_count, samples_checked);
    if (err_count == 0 && samples_checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  initial begin
    #600000;
    err_count++;
    summarize;
  end

  initial begin
    srst = 1'b1; soft_n = 1'b0; empty = 1'b0; wr_en = 1'b0; rd_en = 1'b0;
    addr = 8'h00; wdata = 32'h0; lag = 4'h3;
    repeat (16) @(negedge clk);
    srst = 1'b0;
    rdc(8'h00, 32'h1188, "refresh_control_one");
    rdc(8'h04, 32'h0290, "refresh_control_two");
    rdc(8'h08, 32'h0002, "power_down_control");
    rdc(8'h20, 32'h0000, "unmapped");
    // Settings go in under soft reset, no toggle; slow partner
    wr(8'h00, 32'h280);
    wr(8'h04, 32'h9);
    wr(8'h08, 32'h0);
    soft_n = 1'b1;
    exp_cmd(`DRPC_CMD_PREA);
    exp_cmd(`DRPC_CMD_REF);
    exp_cmd(`DRPC_CMD_REF);
    lag = 4'h0;
    wr(8'h04, 32'h10);
    wr(8'h00, 32'h2c0);
    exp_cmd(`DRPC_CMD_PREA);
    exp_cmd(`DRPC_CMD_REF);
    exp_cmd(`DRPC_CMD_PREA);
    exp_cmd(`DRPC_CMD_REF);
    // Long interval keeps refresh quiet for the low-power part
    wr(8'h04, 32'h7ff8);
    wr(8'h00, 32'h280);
    repeat (150) @(negedge clk);
    q.delete();
    wr(8'h00, 32'h2a0);
    empty = 1'b1;
    exp_cmd(`DRPC_CMD_PREA);
    exp_cmd(`DRPC_CMD_SRE);
    check("low_power", lp, 1);
    empty = 1'b0;
    exp_cmd(`DRPC_CMD_SRX);
    check("low_power", lp, 0);
    wr(8'h00, 32'h280);
    wr(8'h0c, 32'h1);
    rd(8'h08, v);
    wr(8'h08, v | 32'h2);
    empty = 1'b1;
    repeat (20) @(negedge clk);
    check("early_cmds", q.size(), 0);
    exp_cmd(`DRPC_CMD_PREA);
    exp_cmd(`DRPC_CMD_PDE);
    check("low_power", lp, 1);
    wr(8'h08, v);
    exp_cmd(`DRPC_CMD_PDX);
    wr(8'h08, 32'h1);
    exp_cmd(`DRPC_CMD_PREA);
    exp_cmd(`DRPC_CMD_DPDE);
    empty = 1'b0;
    repeat (40) @(negedge clk);
    check("deep_hold", {lp, q.size() != 0}, 2'b10);
    wr(8'h08, 32'h0);
    exp_cmd(`DRPC_CMD_DPDX);
    check("low_power", lp, 0);
    check("dram_order", bad, 0);
    summarize;
  end
endmodule // drpc_ctrl_test
